// ==== design/gauge_pkg.sv ====
// How it works
// - bias added to count each conversion
// - bias recalled from nonvolatile store at power-up
// - three curves, four segments, zero to forty
// - above forty degrees curves stay flat
// - below zero use lowest segment slope
// - curves evaluated in whole degree steps
// - anchors: full mVh and empty fraction
// - standby empty is zero at forty
// - endpoints fixed, four slopes per curve
// - conductance byte converts results to mAh
// - full voltage threshold byte, 19.52 mV step
// - full current threshold byte, 50 uV step
// - empty voltage threshold byte, 19.52 mV step
// - empty current threshold byte, 200 uV step
// - rated wear charge two bytes, count units
// - wear scale byte, 80h means unaged
// - full aged level and mAh scaled by wear factor; learn, aging update
// - wear factor saved periodically, host read/write
// - wear factor recalled at power-up
// - coulomb count saturates at 7fffh and 8000h
// - discharge counter at 32x rated decrements factor
package gauge_pkg;

  // ***********************************
  // apb register map (byte addresses)
  // ***********************************
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_COULOMB = 8'h04;
  localparam logic [7:0] OFF_PAR_BASE = 8'h08;
  localparam logic [7:0] OFF_FULL_LVL = 8'h60;
  localparam logic [7:0] OFF_AE_LVL = 8'h64;
  localparam logic [7:0] OFF_SE_LVL = 8'h68;
  localparam logic [7:0] OFF_AGED_LVL = 8'h6c;
  localparam logic [7:0] OFF_FULL_MAH = 8'h70;

  // ***********************************
  // parameter store indexes
  // ***********************************
  localparam int NPAR = 22;
  localparam logic [4:0] IDX_BIAS = 5'h00;
  localparam logic [4:0] IDX_COND = 5'h01;
  localparam logic [4:0] IDX_FULL_V = 5'h02;
  localparam logic [4:0] IDX_FULL_I = 5'h03;
  localparam logic [4:0] IDX_EMPTY_V = 5'h04;
  localparam logic [4:0] IDX_EMPTY_I = 5'h05;
  localparam logic [4:0] IDX_RATED = 5'h06;
  localparam logic [4:0] IDX_SCALE = 5'h07;
  localparam logic [4:0] IDX_FULL40 = 5'h08;
  localparam logic [4:0] IDX_AE40 = 5'h09;
  localparam logic [4:0] IDX_SLOPE = 5'h0a;
  localparam logic [4:0] IDX_LAST = 5'h15;
  localparam logic [7:0] OFF_PAR_END = 8'h60;
  // byte-wide fields keep the upper byte at zero
  localparam logic [15:0] PAR_MASK [0:NPAR-1] = '{
    16'hffff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff,
    16'hffff, 16'h00ff, 16'hffff, 16'h00ff,
    16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff,
    16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};

  // ***********************************
  // model and scaling constants
  // ***********************************
  localparam int TEMP_FRAC_BITS = 3;
  localparam logic signed [7:0] T_SEG1 = 8'sh0a;
  localparam logic signed [7:0] T_SEG2 = 8'sh14;
  localparam logic signed [7:0] T_SEG3 = 8'sh1e;
  localparam logic signed [7:0] T_SEG4 = 8'sh28;
  localparam logic signed [19:0] SEG_SPAN = 20'sh0000a;
  localparam logic [15:0] LEVEL_FULL40 = 16'h4000;
  localparam int AE40_SHIFT = 6;
  localparam int LEVEL_FRAC_BITS = 14;
  localparam int SCALE_FRAC_BITS = 7;
  localparam logic [7:0] SCALE_UNAGED = 8'h80;
  localparam logic [7:0] SCALE_MIN = 8'h3f;
  localparam int WEAR_MULT_SHIFT = 5;
  localparam logic signed [15:0] COUNT_MAX = 16'sh7fff;
  localparam logic signed [15:0] COUNT_MIN = 16'sh8000;

  // ***********************************
  // timing
  // ***********************************
  localparam longint CLK_HZ = 25000000;
  localparam longint SCALE_SAVE_MS = 1000;
  localparam int SCALE_SAVE_CYC = int'((SCALE_SAVE_MS * CLK_HZ) / 1000);

  typedef enum logic [1:0] {
    ST_LOAD_REQ = 2'b00,
    ST_LOAD_TAKE = 2'b01,
    ST_RUN = 2'b10
  } state_t;

endpackage

// ==== design/nv_store.sv ====
`timescale 1ns/10ps
// no reset on the array: contents must survive a reset
module nv_store (
  // clock
  input wire logic clk,
  // write port
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  // read port, data one cycle after address
  input wire logic [4:0] rd_addr,
  output logic [15:0] rd_data
);

  logic [15:0] mem [0:31];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // nv_store

// ==== design/capacity_model_lookup.sv ====
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module capacity_model_lookup #(
  parameter int SAVE_CYCLES = gauge_pkg::SCALE_SAVE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurements
  input wire logic conv_strobe,
  input wire logic signed [15:0] current_sample,
  input wire logic signed [10:0] temp_sample,
  // learn result
  input wire logic learn_valid,
  input wire logic [7:0] learn_scale,
  // model results
  output logic [15:0] full_level,
  output logic [15:0] active_empty_level,
  output logic [15:0] standby_empty_level,
  output logic [15:0] full_aged_level,
  output logic [15:0] full_capacity_mah,
  // state and thresholds to detectors
  output logic [15:0] coulomb_count,
  output logic [7:0] wear_scale_factor,
  output logic [7:0] full_voltage_threshold,
  output logic [7:0] full_current_threshold,
  output logic [7:0] empty_voltage_threshold,
  output logic [7:0] empty_current_threshold,
  output logic params_loaded
);

  // ***********************************
  // functions
  // ***********************************
  function automatic logic [15:0] clamp_level(input logic signed [19:0] x);
    logic [15:0] r;
    if (x < 20'sh00000)
      r = 16'h0000;
    else if (x > 20'sh0ffff)
      r = 16'hffff;
    else
      r = x[15:0];
    return r;
  endfunction

  function automatic logic [15:0] usat16(input logic [31:0] x);
    logic [15:0] r;
    if (x[31:16] != 16'h0000)
      r = 16'hffff;
    else
      r = x[15:0];
    return r;
  endfunction

  // endpoints from the forty degree anchor downward
  function automatic logic [15:0] curve_at(
    input logic signed [19:0] v40,
    input logic signed [7:0] s0,
    input logic signed [7:0] s1,
    input logic signed [7:0] s2,
    input logic signed [7:0] s3,
    input logic signed [7:0] deg
  );
    logic signed [19:0] v30;
    logic signed [19:0] v20;
    logic signed [19:0] v10;
    logic signed [19:0] v0;
    logic signed [19:0] d;
    logic signed [19:0] r;
    v30 = v40 - 20'(s3) * gauge_pkg::SEG_SPAN;
    v20 = v30 - 20'(s2) * gauge_pkg::SEG_SPAN;
    v10 = v20 - 20'(s1) * gauge_pkg::SEG_SPAN;
    v0 = v10 - 20'(s0) * gauge_pkg::SEG_SPAN;
    d = 20'(deg);
    if (deg >= gauge_pkg::T_SEG4)
      r = v40;
    else if (deg >= gauge_pkg::T_SEG3)
      r = v30 + 20'(s3) * (d - 20'(gauge_pkg::T_SEG3));
    else if (deg >= gauge_pkg::T_SEG2)
      r = v20 + 20'(s2) * (d - 20'(gauge_pkg::T_SEG2));
    else if (deg >= gauge_pkg::T_SEG1)
      r = v10 + 20'(s1) * (d - 20'(gauge_pkg::T_SEG1));
    else
      r = v0 + 20'(s0) * d;
    return clamp_level(r);
  endfunction

  // ***********************************
  // state
  // ***********************************
  gauge_pkg::state_t state_r;
  logic loaded_r;
  logic [4:0] load_idx_r;
  logic [15:0] par_r [0:gauge_pkg::NPAR-1];
  logic [15:0] par_nxt [0:gauge_pkg::NPAR-1];
  logic signed [15:0] count_r;
  logic [21:0] wear_r;
  logic [31:0] save_cnt_r;
  logic save_pend_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [15:0] full_lvl_r;
  logic [15:0] ae_lvl_r;
  logic [15:0] se_lvl_r;
  logic [15:0] aged_lvl_r;
  logic [15:0] mah_r;

  // ***********************************
  // nonvolatile store
  // ***********************************
  wire run = (state_r == gauge_pkg::ST_RUN);
  wire load_take = (state_r == gauge_pkg::ST_LOAD_TAKE);
  wire [15:0] nv_rdata;
  wire apb_commit = psel & penable & pready_r & pwrite & ~pslverr_r;
  wire in_par = (paddr >= gauge_pkg::OFF_PAR_BASE) && (paddr < gauge_pkg::OFF_PAR_END)
                && (paddr[1:0] == 2'b00);
  wire [7:0] par_off = paddr - gauge_pkg::OFF_PAR_BASE;
  wire [4:0] par_idx = par_off[6:2];
  wire apb_wr_par = apb_commit & in_par;
  wire apb_wr_count = apb_commit & (paddr == gauge_pkg::OFF_COULOMB);
  wire apb_wr_scale = apb_wr_par & (par_idx == gauge_pkg::IDX_SCALE);
  // host writes go through to the store; the periodic save waits a cycle
  wire nv_wr_en = apb_wr_par | (run & save_pend_r);
  wire [4:0] nv_wr_addr = apb_wr_par ? par_idx : gauge_pkg::IDX_SCALE;
  wire [15:0] nv_wr_data = apb_wr_par ? (pwdata[15:0] & gauge_pkg::PAR_MASK[par_idx])
                                      : par_r[gauge_pkg::IDX_SCALE];

  nv_store u_store (
    .clk(clk),
    .wr_en(nv_wr_en),
    .wr_addr(nv_wr_addr),
    .wr_data(nv_wr_data),
    .rd_addr(load_idx_r),
    .rd_data(nv_rdata)
  );

  // ***********************************
  // power-up recall
  // ***********************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= gauge_pkg::ST_LOAD_REQ;
      loaded_r <= 1'b0;
      load_idx_r <= 5'h00;
    end
    else
    begin
      case (state_r)
        gauge_pkg::ST_LOAD_REQ:
          state_r <= gauge_pkg::ST_LOAD_TAKE;
        gauge_pkg::ST_LOAD_TAKE:
        begin
          if (load_idx_r == gauge_pkg::IDX_LAST)
          begin
            state_r <= gauge_pkg::ST_RUN;
            loaded_r <= 1'b1;
          end
          else
          begin
            load_idx_r <= load_idx_r + 5'h01;
            state_r <= gauge_pkg::ST_LOAD_REQ;
          end
        end
        default:
        begin
          state_r <= gauge_pkg::ST_RUN;
          loaded_r <= 1'b1;
        end
      endcase
    end
  end

  // ***********************************
  // accumulation and wear
  // ***********************************
  wire signed [15:0] bias = par_r[gauge_pkg::IDX_BIAS];
  wire [15:0] rated = par_r[gauge_pkg::IDX_RATED];
  wire [7:0] scale = par_r[gauge_pkg::IDX_SCALE][7:0];
  // bias shares the current weight, so it simply joins the sum
  wire signed [17:0] acc_sum = 18'(count_r) + 18'(current_sample) + 18'(bias);
  wire signed [15:0] acc_sat = (acc_sum > 18'(gauge_pkg::COUNT_MAX)) ? gauge_pkg::COUNT_MAX :
                               (acc_sum < 18'(gauge_pkg::COUNT_MIN)) ? gauge_pkg::COUNT_MIN :
                               acc_sum[15:0];
  wire accum = run & conv_strobe & ~apb_wr_count;
  wire discharge = accum & (acc_sat < count_r);
  wire [16:0] dec = 17'(18'(count_r) - 18'(acc_sat));
  wire [21:0] wear_sum = wear_r + 22'(dec);
  wire [21:0] wear_limit = 22'(rated) << gauge_pkg::WEAR_MULT_SHIFT;
  // zero rated charge disables aging rather than firing every conversion
  wire wear_hit = discharge & (rated != 16'h0000) & (wear_sum >= wear_limit);
  wire age_step = wear_hit & (scale > gauge_pkg::SCALE_MIN);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_r <= 16'sh0000;
      wear_r <= 22'h000000;
    end
    else
    begin
      if (apb_wr_count)
        count_r <= pwdata[15:0];
      else if (accum)
        count_r <= acc_sat;
      if (wear_hit)
        wear_r <= wear_sum - wear_limit;
      else if (discharge)
        wear_r <= wear_sum;
    end
  end

  // ***********************************
  // parameter registers
  // ***********************************
  always_comb
  begin
    for (int i = 0; i < gauge_pkg::NPAR; i++)
      par_nxt[i] = par_r[i];
    if (load_take)
      par_nxt[load_idx_r] = nv_rdata & gauge_pkg::PAR_MASK[load_idx_r];
    else
    begin
      if (learn_valid & run)
        par_nxt[gauge_pkg::IDX_SCALE] = {8'h00, learn_scale};
      else if (age_step)
        par_nxt[gauge_pkg::IDX_SCALE] = {8'h00, scale - 8'h01};
      if (apb_wr_par)
        par_nxt[par_idx] = pwdata[15:0] & gauge_pkg::PAR_MASK[par_idx];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < gauge_pkg::NPAR; i++)
        par_r[i] <= 16'h0000;
    end
    else
    begin
      for (int i = 0; i < gauge_pkg::NPAR; i++)
        par_r[i] <= par_nxt[i];
    end
  end

  // ***********************************
  // periodic save of the wear factor
  // ***********************************
  wire save_tick = run & (save_cnt_r == 32'(SAVE_CYCLES - 1));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      save_cnt_r <= 32'h00000000;
      save_pend_r <= 1'b0;
    end
    else
    begin
      if (save_tick)
        save_cnt_r <= 32'h00000000;
      else if (run)
        save_cnt_r <= save_cnt_r + 32'h00000001;
      // a new tick wins over the clear of the pending save
      if (save_tick)
        save_pend_r <= 1'b1;
      else if (run & ~apb_wr_par)
        save_pend_r <= 1'b0;
    end
  end

  // ***********************************
  // curve lookup
  // ***********************************
  // fractional degrees are dropped, so curves move in one degree steps
  wire signed [7:0] deg = temp_sample[10:gauge_pkg::TEMP_FRAC_BITS];
  wire signed [19:0] full40 = 20'(gauge_pkg::LEVEL_FULL40);
  wire signed [19:0] ae40 = 20'(par_r[gauge_pkg::IDX_AE40]) <<< gauge_pkg::AE40_SHIFT;
  wire signed [19:0] se40 = 20'sh00000;
  wire signed [7:0] slope [0:11];

  genvar g;
  for (g = 0; g < 12; g++)
  begin : g_slope
    assign slope[g] = par_r[gauge_pkg::IDX_SLOPE + 5'(g)][7:0];
  end

  wire [15:0] full_now = curve_at(full40, slope[0], slope[1], slope[2], slope[3], deg);
  wire [15:0] ae_now = curve_at(ae40, slope[4], slope[5], slope[6], slope[7], deg);
  wire [15:0] se_now = curve_at(se40, slope[8], slope[9], slope[10], slope[11], deg);

  // ***********************************
  // aged and absolute results
  // ***********************************
  wire [23:0] aged_prod = full_lvl_r * scale;
  wire [15:0] aged_now = usat16(32'(aged_prod >> gauge_pkg::SCALE_FRAC_BITS));
  wire [31:0] mvh_prod = aged_lvl_r * par_r[gauge_pkg::IDX_FULL40];
  wire [17:0] mvh_now = mvh_prod[31:gauge_pkg::LEVEL_FRAC_BITS];
  wire [25:0] mah_prod = mvh_now * par_r[gauge_pkg::IDX_COND][7:0];
  wire [15:0] mah_now = usat16(32'(mah_prod));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      full_lvl_r <= 16'h0000;
      ae_lvl_r <= 16'h0000;
      se_lvl_r <= 16'h0000;
      aged_lvl_r <= 16'h0000;
      mah_r <= 16'h0000;
    end
    else
    begin
      full_lvl_r <= full_now;
      ae_lvl_r <= ae_now;
      se_lvl_r <= se_now;
      aged_lvl_r <= aged_now;
      mah_r <= mah_now;
    end
  end

  // ***********************************
  // apb slave
  // ***********************************
  logic [31:0] rd_mux;
  logic unmapped;

  always_comb
  begin
    rd_mux = 32'h00000000;
    unmapped = 1'b0;
    if (paddr == gauge_pkg::OFF_STATUS)
      rd_mux = {31'h00000000, run};
    else if (paddr == gauge_pkg::OFF_COULOMB)
      rd_mux = {16'h0000, count_r};
    else if (in_par)
      rd_mux = {16'h0000, par_r[par_idx]};
    else if (paddr == gauge_pkg::OFF_FULL_LVL)
      rd_mux = {16'h0000, full_lvl_r};
    else if (paddr == gauge_pkg::OFF_AE_LVL)
      rd_mux = {16'h0000, ae_lvl_r};
    else if (paddr == gauge_pkg::OFF_SE_LVL)
      rd_mux = {16'h0000, se_lvl_r};
    else if (paddr == gauge_pkg::OFF_AGED_LVL)
      rd_mux = {16'h0000, aged_lvl_r};
    else if (paddr == gauge_pkg::OFF_FULL_MAH)
      rd_mux = {16'h0000, mah_r};
    else
      unmapped = 1'b1;
  end

  // one wait state; transfers stall until recall has finished
  wire access = psel & penable & run & ~pready_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= access;
      pslverr_r <= access & unmapped;
      if (access & ~pwrite)
        prdata_r <= rd_mux;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign full_level = full_lvl_r;
  assign active_empty_level = ae_lvl_r;
  assign standby_empty_level = se_lvl_r;
  assign full_aged_level = aged_lvl_r;
  assign full_capacity_mah = mah_r;
  assign coulomb_count = count_r;
  assign wear_scale_factor = par_r[gauge_pkg::IDX_SCALE][7:0];
  assign full_voltage_threshold = par_r[gauge_pkg::IDX_FULL_V][7:0];
  assign full_current_threshold = par_r[gauge_pkg::IDX_FULL_I][7:0];
  assign empty_voltage_threshold = par_r[gauge_pkg::IDX_EMPTY_V][7:0];
  assign empty_current_threshold = par_r[gauge_pkg::IDX_EMPTY_I][7:0];
  assign params_loaded = loaded_r;

endmodule // capacity_model_lookup

// ==== tb/gauge_chk.sv ====
`timescale 1ns/10ps
// ***************************************
// port checker
// ***************************************
module gauge_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // measurements
  input wire logic conv_strobe,
  input wire logic signed [10:0] temp_sample,
  input wire logic learn_valid,
  input wire logic [7:0] learn_scale,
  // results
  input wire logic [15:0] full_level,
  input wire logic [15:0] standby_empty_level,
  input wire logic [15:0] full_aged_level,
  input wire logic [15:0] coulomb_count,
  input wire logic [7:0] wear_scale_factor,
  input wire logic params_loaded
);
  // store is unknown until first fully written, so the whole-degree and aged-scale checks wait for that
  logic armed_r;
  logic hot;
  assign hot = params_loaded && ($signed(temp_sample[10:3]) >= 8'sh28);
  always_ff @(posedge clk)
  begin
    armed_r <= armed_r || (psel && penable && pready && pwrite && paddr == 8'h5c);
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  chk_one_wait: assert property (psel && penable && params_loaded && !pready |=> pready)
    else $error("access not answered after one wait");
  chk_bad_addr: assert property (pready && (paddr > 8'h70 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access without error");
  chk_count_hold: assert property (!conv_strobe && !psel |=> $stable(coulomb_count))
    else $error("count moved without conversion");
  chk_learn_load: assert property (learn_valid && params_loaded && !psel && !conv_strobe
    |=> wear_scale_factor == $past(learn_scale))
    else $error("learn result not loaded");
  chk_hot_full: assert property (hot |=> full_level == 16'h4000)
    else $error("full not flat above forty");
  chk_se_zero: assert property (hot |=> standby_empty_level == 16'h0000)
    else $error("standby empty not zero at forty");
  chk_whole_deg: assert property (armed_r && params_loaded && $past(params_loaded) && !psel
    && !$past(psel) && $stable(temp_sample[10:3]) |=> $stable(full_level))
    else $error("level moved within one degree");
  chk_aged_scale: assert property ((armed_r && params_loaded && $stable(full_level)
    && $stable(wear_scale_factor)) [*2]
    |-> full_aged_level == 16'((32'(full_level) * 32'(wear_scale_factor)) >> 7))
    else $error("aged level not scaled");

  cov_conv: cover property (conv_strobe && params_loaded);
  cov_err: cover property (pready && pslverr);
  cov_learn: cover property (learn_valid && params_loaded);
endmodule // gauge_chk

bind capacity_model_lookup gauge_chk u_chk (.clk(clk), .nrst(nrst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .conv_strobe(conv_strobe), .temp_sample(temp_sample), .learn_valid(learn_valid),
  .learn_scale(learn_scale), .full_level(full_level),
  .standby_empty_level(standby_empty_level), .full_aged_level(full_aged_level),
  .coulomb_count(coulomb_count), .wear_scale_factor(wear_scale_factor),
  .params_loaded(params_loaded));

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
// ***************************************
// bench top
// ***************************************
module tb_top;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic conv_strobe, learn_valid, params_loaded, r_err;
  logic [7:0] paddr, learn_scale, wear_scale_factor;
  logic [7:0] full_voltage_threshold, full_current_threshold;
  logic [7:0] empty_voltage_threshold, empty_current_threshold;
  logic [31:0] pwdata, prdata, r_data;
  logic signed [15:0] current_sample;
  logic signed [10:0] temp_sample;
  logic [15:0] full_level, active_empty_level, standby_empty_level;
  logic [15:0] full_aged_level, full_capacity_mah, coulomb_count;
  int failures, tests_run, t;
  int temps [0:8] = '{40, 45, 35, 25, 20, 12, 3, 0, -5};
  // bias, conductance, four thresholds, rated, scale, anchors, 12 slopes
  logic [15:0] pv [0:21] = '{16'h0003, 16'h0032, 16'h00d7, 16'h0014, 16'h009a,
    16'h001e, 16'h0001, 16'h0080, 16'h0100, 16'h0021, 16'h000a, 16'h0014, 16'h001e,
    16'h0028, 16'h00f0, 16'h00f0, 16'h00f0, 16'h00f0, 16'h00fb, 16'h00f6, 16'h00fb,
    16'h00fe};

  capacity_model_lookup #(.SAVE_CYCLES(50)) dut (.clk(clk), .nrst(nrst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_strobe(conv_strobe),
    .current_sample(current_sample), .temp_sample(temp_sample),
    .learn_valid(learn_valid), .learn_scale(learn_scale), .full_level(full_level),
    .active_empty_level(active_empty_level), .standby_empty_level(standby_empty_level),
    .full_aged_level(full_aged_level), .full_capacity_mah(full_capacity_mah),
    .coulomb_count(coulomb_count), .wear_scale_factor(wear_scale_factor),
    .full_voltage_threshold(full_voltage_threshold),
    .full_current_threshold(full_current_threshold),
    .empty_voltage_threshold(empty_voltage_threshold),
    .empty_current_threshold(empty_current_threshold), .params_loaded(params_loaded));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ***************************************
  // helpers
  // ***************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // slope byte k of the curve starting at store index b
  function automatic int slp(int b, int k);
    return int'($signed(pv[b + k][7:0]));
  endfunction

  function automatic int curve(int v40, int b, int t);
    int v3, v2, v1, v0, r;
    v3 = v40 - 10 * slp(b, 3);
    v2 = v3 - 10 * slp(b, 2);
    v1 = v2 - 10 * slp(b, 1);
    v0 = v1 - 10 * slp(b, 0);
    if (t >= 40)
      r = v40;
    else if (t >= 30)
      r = v3 + slp(b, 3) * (t - 30);
    else if (t >= 20)
      r = v2 + slp(b, 2) * (t - 20);
    else if (t >= 10)
      r = v1 + slp(b, 1) * (t - 10);
    else
      r = v0 + slp(b, 0) * t;
    return (r < 0) ? 0 : ((r > 65535) ? 65535 : r);
  endfunction

  // request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    while (pready !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    r_data = prdata;
    r_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      test_done;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r_data, exp);
  endtask

  task automatic conv(input logic [15:0] c, input logic [15:0] exp);
    @(posedge clk);
    conv_strobe <= 1'b1;
    current_sample <= c;
    @(posedge clk);
    conv_strobe <= 1'b0;
    @(posedge clk);
    chk(coulomb_count, exp);
  endtask

  task automatic do_reset;
    int n;
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    n = 0;
    while (params_loaded !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk(params_loaded, 1);
    if (params_loaded !== 1'b1)
      test_done;
  endtask

  // ***************************************
  // sequence
  // ***************************************
  initial
  begin
    {nrst, psel, penable, pwrite, conv_strobe, learn_valid} = 6'h00;
    {paddr, learn_scale, pwdata, current_sample} = '0;
    temp_sample = 11'sh140;
    failures = 0;
    tests_run = 0;
    do_reset;
    for (int i = 0; i < 22; i++)
      apb(1'b1, 8'(8 + 4 * i), {16'h0000, pv[i]});
    do_reset;
    for (int i = 0; i < 22; i++)
      rd(8'(8 + 4 * i), {16'h0000, pv[i] & gauge_pkg::PAR_MASK[i]});
    chk(full_voltage_threshold, pv[2]);
    chk(full_current_threshold, pv[3]);
    chk(empty_voltage_threshold, pv[4]);
    chk(empty_current_threshold, pv[5]);
    chk(wear_scale_factor, 8'h80);
    rd(8'h00, 32'h1);
    apb(1'b0, 8'h74, 32'h0);
    chk(r_err, 32'h1);
    chk(r_data, 32'h0);
    // unaligned write must fail and leave the bias alone
    apb(1'b1, 8'h0a, 32'hff);
    chk(r_err, 32'h1);
    rd(8'h08, {16'h0000, pv[0]});
    // fraction bits set on purpose: only whole degrees may count
    foreach (temps[i])
    begin
      t = temps[i];
      @(posedge clk);
      temp_sample <= 11'(t * 8 + 5);
      repeat (4) @(posedge clk);
      chk(full_level, 32'(curve(16384, 10, t)));
      chk(active_empty_level, 32'(curve(int'(pv[9]) * 64, 14, t)));
      chk(standby_empty_level, 32'(curve(0, 18, t)));
      chk(full_aged_level, 32'(curve(16384, 10, t)));
    end
    @(posedge clk);
    temp_sample <= 11'sh140;
    repeat (4) @(posedge clk);
    chk(full_capacity_mah, 16'h3200);
    rd(8'h70, 32'h3200);
    @(posedge clk);
    learn_valid <= 1'b1;
    learn_scale <= 8'h40;
    @(posedge clk);
    learn_valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk(wear_scale_factor, 8'h40);
    chk(full_aged_level, 16'h2000);
    chk(full_capacity_mah, 16'h1900);
    apb(1'b1, 8'h24, 32'h7a);
    rd(8'h24, 32'h7a);
    apb(1'b1, 8'h04, 32'h0);
    conv(16'hffdd, 16'hffe0);
    repeat (2) @(posedge clk);
    chk(wear_scale_factor, 8'h79);
    conv(16'hffec, 16'hffcf);
    repeat (3) @(posedge clk);
    chk(wear_scale_factor, 8'h79);
    // aged factor only survives reset through the periodic save
    repeat (120) @(posedge clk);
    do_reset;
    rd(8'h24, 32'h79);
    apb(1'b1, 8'h04, 32'h0100);
    conv(16'h0010, 16'h0113);
    apb(1'b1, 8'h04, 32'h7ff0);
    conv(16'h7fff, 16'h7fff);
    apb(1'b1, 8'h04, 32'h8010);
    conv(16'hffc0, 16'h8000);
    test_done;
  end
endmodule // tb_top
